// [hdl/ivc_map.vh]
`ifndef IVC_MAP_VH
`define IVC_MAP_VH
// ----------------------------------------
// Flag and mask bit positions
// ----------------------------------------
`define IVC_BIT_TICK 0
`define IVC_BIT_PCHG 1
`define IVC_BIT_CMP 2
`define IVC_BIT_EXT 3
`define IVC_BIT_PWM 4
`define IVC_NSRC 5
// ----------------------------------------
// Vector addresses
// ----------------------------------------
`define IVC_VEC_EXT 10'h003
`define IVC_VEC_PCHG 10'h006
`define IVC_VEC_TICK 10'h009
`define IVC_VEC_CMP 10'h00C
`define IVC_VEC_PWM 10'h00F
// ----------------------------------------
// Reset values
// ----------------------------------------
`define IVC_FLAG_RST 5'h00
`define IVC_MASK_RST 5'h00
`define IVC_PWM_RST 10'h000
`endif

// [hdl/ivc_sync2.v]
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------
module ivc_sync2 #(
   parameter W = 8
) (
   input wire mclk,
   input wire rst,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule

// [hdl/ivc_pwm_timer.v]
`timescale 1ns/1ps
`include "ivc_map.vh"
// ----------------------------------------
// Period counter: counts on each increment tick, clears after the match
// ----------------------------------------
module ivc_pwm_timer #(
   parameter W = 10
) (
   input wire mclk,
   input wire rst,
   input wire tick,
   input wire [W-1:0] pwm_period_value,
   output wire [W-1:0] pwm_timer_count,
   output wire match_evt
);
   reg [W-1:0] cnt_q;
   reg evt_q;
   // The tick after the count has reached the period clears it and raises the event
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= {W{1'b0}};
         evt_q <= 1'b0;
      end else begin
         evt_q <= 1'b0;
         if (tick) begin
            if (cnt_q == pwm_period_value) begin
               cnt_q <= {W{1'b0}};
               evt_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
   assign pwm_timer_count = cnt_q;
   assign match_evt = evt_q;
endmodule

// [hdl/ivc_core.v]
`timescale 1ns/1ps
`include "ivc_map.vh"
// Notes on behaviour
// - Five sources: tick overflow, port change, external pin, PWM match, comparator.
// - Port change on any input pin; outputs and pin 0 as external input excluded.
// - Port change wakes sleep only if detection was enabled before sleeping.
// - After pin-change wake: continue in line if disabled, else vector 006H.
// - Enable instruction sets global enable; disable instruction clears it.
// - Unmasked request with global enable redirects next fetch to its vector.
// - Flags other than port change set regardless of mask or global enable.
// - Effective request is flag AND mask.
// - Return instruction ends routine and sets global enable.
// - Save accumulator, status, register select on entry; restore on return.
// - A later entry overwrites the single saved copy.
// - Priority external 003H, port 006H, tick 009H, comparator 00CH, PWM 00FH.
// - PWM flag set on the increment after count equals period, with clear.
// - Comparator flag set on every output change, either direction, while cmp_enable is on.
// - Comparator interrupt taken only with its mask bit set.
// - Comparator flag cleared only by software.
// - Current comparator result readable as a status bit.
// - Enabled comparator stays active in sleep; a change wakes the device.
module ivc_core #(
   parameter PW = 10,
   parameter AW = 10
) (
   input wire mclk,
   input wire rst,
   // Pins
   input wire [7:0] port6_pins,
   input wire [7:0] port6_is_output,
   input wire ext_irq_sel,
   input wire cmp_out_pin,
   input wire cmp_enable,
   // Timer sources
   input wire tick_overflow,
   input wire pwm_tick,
   input wire [PW-1:0] pwm_period_value,
   output wire [PW-1:0] pwm_timer_count,
   // Core instruction strobes
   input wire global_irq_on_instr,
   input wire global_irq_off_instr,
   input wire irq_return_instr,
   input wire sleep_instr,
   input wire port6_read,
   // Flag and mask registers
   input wire flag_wr,
   input wire [4:0] flag_wdata,
   input wire mask_wr,
   input wire [4:0] mask_wdata,
   output wire [4:0] irq_flag_reg,
   output wire [4:0] irq_mask_reg,
   output wire cmp_result_bit,
   output wire global_irq_en,
   // Context
   input wire [7:0] acc_in,
   input wire [7:0] status_word_in,
   input wire [7:0] register_select_pointer_in,
   output wire [7:0] acc_saved,
   output wire [7:0] status_word_saved,
   output wire [7:0] register_select_pointer_saved,
   output wire ctx_restore,
   // Fetch redirect
   input wire fetch_slot,
   output wire vector_take,
   output wire [AW-1:0] vector_addr,
   output wire sleeping,
   output wire wake_up
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   wire [7:0] p6_s;
   wire [1:0] misc_s;
   ivc_sync2 #(.W(8)) u_sync_p6 (
      .mclk(mclk),
      .rst(rst),
      .async_in(port6_pins),
      .sync_out(p6_s)
   );
   ivc_sync2 #(.W(2)) u_sync_misc (
      .mclk(mclk),
      .rst(rst),
      .async_in({cmp_out_pin, port6_pins[0]}),
      .sync_out(misc_s)
   );

   // ----------------------------------------
   // PWM period timer
   // ----------------------------------------
   wire pwm_evt;
   ivc_pwm_timer #(.W(PW)) u_pwm (
      .mclk(mclk),
      .rst(rst),
      .tick(pwm_tick & ~sleeping),
      .pwm_period_value(pwm_period_value),
      .pwm_timer_count(pwm_timer_count),
      .match_evt(pwm_evt)
   );

   // ----------------------------------------
   // Event detection
   // ----------------------------------------
   reg [7:0] p6_prev_q;
   reg ext_prev_q;
   reg cmp_prev_q;
   reg [7:0] in_mask;
   reg p6_chg;
   integer i;
   always @* begin
      in_mask = ~port6_is_output;
      if (ext_irq_sel) begin
         in_mask[0] = 1'b0;
      end
      p6_chg = 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
         p6_chg = p6_chg | (in_mask[i] & (p6_s[i] ^ p6_prev_q[i]));
      end
   end
   wire ext_evt = ext_irq_sel & ext_prev_q & ~misc_s[0];
   wire cmp_evt = cmp_enable & (misc_s[1] ^ cmp_prev_q);

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         p6_prev_q <= 8'h00;
         ext_prev_q <= 1'b0;
         cmp_prev_q <= 1'b0;
      end else begin
         // A port read or a detected change rearms the port 6 reference levels
         if (port6_read | p6_chg) begin
            p6_prev_q <= p6_s;
         end
         ext_prev_q <= misc_s[0];
         cmp_prev_q <= misc_s[1];
      end
   end
   assign cmp_result_bit = cmp_prev_q;

   // ----------------------------------------
   // Flags and mask
   // ----------------------------------------
   reg [4:0] flag_q;
   reg [4:0] mask_q;
   reg [4:0] set_v;
   always @* begin
      set_v = 5'h00;
      set_v[`IVC_BIT_TICK] = tick_overflow;
      set_v[`IVC_BIT_EXT] = ext_evt;
      set_v[`IVC_BIT_CMP] = cmp_evt;
      set_v[`IVC_BIT_PWM] = pwm_evt;
      // Port-change flag only latches while its mask bit is on
      set_v[`IVC_BIT_PCHG] = p6_chg & mask_q[`IVC_BIT_PCHG];
   end
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_q <= `IVC_FLAG_RST;
         mask_q <= `IVC_MASK_RST;
      end else begin
         // Set wins over a software clear in the same cycle
         if (flag_wr) begin
            flag_q <= (flag_q & flag_wdata) | set_v;
         end else begin
            flag_q <= flag_q | set_v;
         end
         if (mask_wr) begin
            mask_q <= mask_wdata;
         end
      end
   end
   assign irq_flag_reg = flag_q;
   assign irq_mask_reg = mask_q;
   wire [4:0] req = flag_q & mask_q;

   // ----------------------------------------
   // Priority and vector
   // ----------------------------------------
   function [AW-1:0] pick_vec;
      input [4:0] r;
      begin
         if (r[`IVC_BIT_EXT]) begin
            pick_vec = `IVC_VEC_EXT;
         end else if (r[`IVC_BIT_PCHG]) begin
            pick_vec = `IVC_VEC_PCHG;
         end else if (r[`IVC_BIT_TICK]) begin
            pick_vec = `IVC_VEC_TICK;
         end else if (r[`IVC_BIT_CMP]) begin
            pick_vec = `IVC_VEC_CMP;
         end else begin
            pick_vec = `IVC_VEC_PWM;
         end
      end
   endfunction

   // ----------------------------------------
   // Global enable, sleep, entry and context
   // ----------------------------------------
   reg gie_q;
   reg sleep_q;
   reg wake_q;
   reg restore_q;
   reg [AW-1:0] vec_q;
   reg [7:0] acc_q;
   reg [7:0] stat_q;
   reg [7:0] rsel_q;
   wire take = gie_q & (|req) & fetch_slot & ~sleep_q;
   wire wake_evt = sleep_q & ((p6_chg & mask_q[`IVC_BIT_PCHG]) | cmp_evt);

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gie_q <= 1'b0;
         sleep_q <= 1'b0;
         wake_q <= 1'b0;
         restore_q <= 1'b0;
         vec_q <= {AW{1'b0}};
         acc_q <= 8'h00;
         stat_q <= 8'h00;
         rsel_q <= 8'h00;
      end else begin
         wake_q <= wake_evt;
         restore_q <= irq_return_instr;
         if (sleep_instr) begin
            sleep_q <= 1'b1;
         end else if (wake_evt) begin
            sleep_q <= 1'b0;
         end
         if (take) begin
            gie_q <= 1'b0;
            vec_q <= pick_vec(req);
            acc_q <= acc_in;
            stat_q <= status_word_in;
            rsel_q <= register_select_pointer_in;
         end else if (global_irq_on_instr | irq_return_instr) begin
            gie_q <= 1'b1;
         end else if (global_irq_off_instr) begin
            gie_q <= 1'b0;
         end
      end
   end
   assign global_irq_en = gie_q;
   assign vector_take = take;
   assign vector_addr = vec_q;
   assign acc_saved = acc_q;
   assign status_word_saved = stat_q;
   assign register_select_pointer_saved = rsel_q;
   assign ctx_restore = restore_q;
   assign sleeping = sleep_q;
   assign wake_up = wake_q;
endmodule

// [verif/ivc_core_props.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the interrupt core
// ----------------------------------------
module ivc_core_props #(
   parameter AW = 10
) (
   input logic mclk,
   input logic rst,
   input logic global_irq_on_instr,
   input logic global_irq_off_instr,
   input logic irq_return_instr,
   input logic flag_wr,
   input logic fetch_slot,
   input logic sleeping,
   input logic [7:0] acc_in,
   input logic [4:0] irq_flag_reg,
   input logic [4:0] irq_mask_reg,
   input logic global_irq_en,
   input logic [7:0] acc_saved,
   input logic ctx_restore,
   input logic vector_take,
   input logic [AW-1:0] vector_addr
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_ret;
      irq_return_instr ##1 (ctx_restore && global_irq_en);
   endsequence
   property p_take;
      vector_take |-> global_irq_en && |(irq_flag_reg & irq_mask_reg) && fetch_slot && !sleeping;
   endproperty
   property p_gie_off;
      vector_take |=> !global_irq_en;
   endproperty
   property p_on;
      global_irq_on_instr && !vector_take |=> global_irq_en;
   endproperty
   property p_off;
      global_irq_off_instr && !global_irq_on_instr && !irq_return_instr |=> !global_irq_en;
   endproperty
   property p_ret;
      irq_return_instr && !vector_take |-> s_ret;
   endproperty
   property p_vec_top;
      vector_take && irq_flag_reg[3] && irq_mask_reg[3] |=> vector_addr == 10'h003;
   endproperty
   property p_vec_low;
      vector_take && (irq_flag_reg[3:0] & irq_mask_reg[3:0]) == 4'h0 |=> vector_addr == 10'h00f;
   endproperty
   property p_hold;
      !vector_take |=> $stable(vector_addr);
   endproperty
   property p_flags;
      !flag_wr |=> (irq_flag_reg & $past(irq_flag_reg)) == $past(irq_flag_reg);
   endproperty
   property p_ctx;
      vector_take |=> acc_saved == $past(acc_in);
   endproperty
   a_take: assert property (p_take)
      else $error("vector taken without cause");
   a_gie_off: assert property (p_gie_off)
      else $error("global enable kept after take");
   a_on: assert property (p_on)
      else $error("enable instruction ignored");
   a_off: assert property (p_off)
      else $error("disable instruction ignored");
   a_ret: assert property (p_ret)
      else $error("return did not restore");
   a_vec_top: assert property (p_vec_top)
      else $error("external source not first");
   a_vec_low: assert property (p_vec_low)
      else $error("pwm vector wrong");
   a_hold: assert property (p_hold)
      else $error("vector moved without take");
   a_flags: assert property (p_flags)
      else $error("flag dropped without write");
   a_ctx: assert property (p_ctx)
      else $error("context not saved");
endmodule
bind ivc_core ivc_core_props #(.AW(AW)) u_props (.mclk(mclk), .rst(rst),
   .global_irq_on_instr(global_irq_on_instr), .global_irq_off_instr(global_irq_off_instr),
   .irq_return_instr(irq_return_instr), .flag_wr(flag_wr), .fetch_slot(fetch_slot),
   .sleeping(sleeping), .acc_in(acc_in), .irq_flag_reg(irq_flag_reg),
   .irq_mask_reg(irq_mask_reg), .global_irq_en(global_irq_en), .acc_saved(acc_saved),
   .ctx_restore(ctx_restore), .vector_take(vector_take), .vector_addr(vector_addr));

// [verif/ivc_core_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Core side: fetch boundaries and live context
// ----------------------------------------
module ivc_core_model (
   input wire mclk,
   input wire slow,
   output logic fetch_slot,
   output logic [7:0] acc,
   output logic [7:0] status_word,
   output logic [7:0] register_select_pointer
);
   int n = 0;
   initial begin
      fetch_slot = 1'b0;
      acc = 8'h00;
      status_word = 8'h00;
      register_select_pointer = 8'h00;
   end
   // Context changes every cycle so a late capture is seen
   always @(negedge mclk) begin
      n <= n + 1;
      fetch_slot <= slow ? (n % 4 == 0) : 1'b1;
      acc <= 8'($urandom);
      status_word <= 8'($urandom);
      register_select_pointer <= 8'($urandom);
   end
endmodule

// [verif/interrupt_vector_controller_tb_top.sv]
`timescale 1ns/1ps
module interrupt_vector_controller_tb_top;
   logic mclk = 0, rst = 1, ext_sel = 1, cmp_pin = 0, slow = 0;
   logic [7:0] pins = 8'hff;
   logic [8:0] strb = 9'h000;
   logic [4:0] wd = 5'h00;
   logic [9:0] period = 10'h003;
   wire slot, take, cres, gie, rest, slp, wake;
   wire [7:0] acc, sw, rsp, acc_s, sw_s, rsp_s;
   wire [4:0] flg, msk;
   wire [9:0] cnt, vaddr;
   int failures = 0, comparisons = 0, exp_flag = 0, a, s, r, t;
   int bitq[$] = {3, 1, 0, 2, 4};
   int vecq[$] = {3, 6, 9, 12, 15};
   initial forever #2.5 mclk = ~mclk;
   ivc_core_model u_core (.mclk(mclk), .slow(slow), .fetch_slot(slot), .acc(acc),
      .status_word(sw), .register_select_pointer(rsp));
   ivc_core dut (.mclk(mclk), .rst(rst), .port6_pins(pins), .port6_is_output(8'h80),
      .ext_irq_sel(ext_sel), .cmp_out_pin(cmp_pin), .cmp_enable(1'b1),
      .tick_overflow(strb[7]), .pwm_tick(strb[8]), .pwm_period_value(period),
      .pwm_timer_count(cnt), .global_irq_on_instr(strb[0]), .global_irq_off_instr(strb[1]),
      .irq_return_instr(strb[2]), .sleep_instr(strb[3]), .port6_read(strb[4]),
      .flag_wr(strb[5]), .flag_wdata(wd), .mask_wr(strb[6]), .mask_wdata(wd),
      .irq_flag_reg(flg), .irq_mask_reg(msk), .cmp_result_bit(cres), .global_irq_en(gie),
      .acc_in(acc), .status_word_in(sw), .register_select_pointer_in(rsp),
      .acc_saved(acc_s), .status_word_saved(sw_s), .register_select_pointer_saved(rsp_s),
      .ctx_restore(rest), .fetch_slot(slot), .vector_take(take), .vector_addr(vaddr),
      .sleeping(slp), .wake_up(wake));
   task check(input logic [15:0] seen, input logic [15:0] exp, input string m);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task pulse(input logic [8:0] p, input logic [4:0] d);
      @(negedge mclk) strb = p;
      wd = d;
      @(negedge mclk) strb = 9'h000;
   endtask
   task waitn(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      failures++;
      results;
   end
   initial begin
      void'($urandom(28946));
      repeat (8) @(posedge mclk);
      @(negedge mclk) rst = 0;
      check(flg, 0, "flags after reset");
      check(gie, 0, "enable after reset");
      pulse(9'h080, 5'h00);
      waitn(2);
      exp_flag = 1;
      check(flg, exp_flag, "tick flag unmasked");
      pulse(9'h020, 5'h1f);
      check(flg, exp_flag, "write one keeps");
      pulse(9'h020, 5'h1e);
      exp_flag = 0;
      check(flg, exp_flag, "write zero clears");
      $display("flag test done");
      for (int i = 0; i < 2; i++) begin
         @(negedge mclk) cmp_pin = ~cmp_pin;
         waitn(6);
         check(flg[2], 1, "comparator flag");
         check(cres, cmp_pin, "comparator level");
         waitn(20);
         check(flg[2], 1, "comparator flag held");
         pulse(9'h020, 5'h1b);
         check(flg, 0, "comparator flag cleared");
      end
      $display("comparator test done");
      period = 10'($urandom_range(2, 6));
      repeat (period) pulse(9'h100, 5'h00);
      waitn(2);
      check(cnt, period, "count at period");
      check(flg[4], 0, "pwm flag early");
      pulse(9'h100, 5'h00);
      waitn(2);
      check(flg[4], 1, "pwm flag");
      check(cnt, 0, "count cleared");
      $display("pwm test done");
      pulse(9'h080, 5'h00);
      @(negedge mclk) cmp_pin = ~cmp_pin;
      pulse(9'h010, 5'h00);
      pulse(9'h040, 5'h1f);
      check(msk, 5'h1f, "mask loaded");
      @(negedge mclk) pins = pins ^ (8'h01 << $urandom_range(1, 6)) ^ 8'h01;
      waitn(6);
      exp_flag = 31;
      check(flg, exp_flag, "all sources flagged");
      pulse(9'h001, 5'h00);
      for (int i = 0; i < 5; i++) begin
         slow = (i > 2);
         for (t = 0; t < 40; t++) begin
            #1;
            if (take) break;
            @(negedge mclk);
         end
         a = acc;
         s = sw;
         r = rsp;
         check(t < 40, 1, "no vector taken");
         @(negedge mclk);
         check(vaddr, vecq[i], "vector order");
         check(gie, 0, "enable after take");
         check({acc_s, sw_s}, {a[7:0], s[7:0]}, "saved context");
         check(rsp_s, r, "saved select");
         exp_flag = exp_flag & ~(1 << bitq[i]);
         pulse(9'h020, ~(5'h01 << bitq[i]));
         check(flg, exp_flag, "serviced flag cleared");
         pulse(9'h004, 5'h00);
         check({rest, gie}, 2'b11, "return restores");
      end
      $display("priority test done");
      pulse(9'h002, 5'h00);
      check(gie, 0, "disable instruction");
      pulse(9'h040, 5'h04);
      check(msk, 5'h04, "comparator mask only");
      pulse(9'h008, 5'h00);
      check(slp, 1, "sleep entered");
      @(negedge mclk) cmp_pin = ~cmp_pin;
      for (t = 0; t < 20; t++) begin
         #1;
         if (wake) break;
         @(negedge mclk);
      end
      check(t < 20, 1, "comparator wake");
      waitn(2);
      check(slp, 0, "awake");
      check(flg[2], 1, "flag set in sleep");
      $display("sleep test done");
      results;
   end
endmodule
